// [design/serial_eeprom_command_port.sv]
// Serial command port of a small electrically erasable memory, device side.
//
// Overview of operation
// - Chip select high selects the device; low deselects it into standby.
// - A started programming cycle always completes regardless of chip select.
// - While chip select is low the command logic is held in reset.
// - Input bits are sampled and output bits advanced on rising serial clock edges.
// - Serial clock may pause at either level without losing the sequence position.
// - Clock ignored while deselected; before start bit edges change nothing.
// - Self-timed programming needs no serial clock edges.
// - Act only after all bits; then ignore clock and input until next start.
// - Read data bits are driven on the output after each rising edge.
// - Status appears when chip select rises after a long enough low time, if programming started since the last start bit.
// - No status if select never toggles; otherwise output is high impedance.
// - Width select low gives byte words, high gives 16-bit words on 1K and 2K; 4K stays byte width.
// - Start bit 1, then opcode: 10 read, 01 write, 11 erase, 00 extended.
// - Extended: top address bits 11 enable, 00 disable, 10 erase all, 01 write all.
// - 1K byte width: 7 address bits, 18 or 10 clocks.
// - 1K word width: 6 address bits, 25 or 9 clocks.
// - 2K byte width: 9 address bits, leading one ignored, 20 or 12 clocks.
// - 2K word width: 8 address bits, leading one ignored, 27 or 11 clocks.
// - 4K byte width: 9 significant address bits, 20 or 12 clocks.
// - Start bit is the first rising edge with select and input both high, not taken while busy or while a job is pending.
// - Status output is low while programming and high when ready.
// - Programming is disabled after reset until an enable command runs.
// - Read sends one zero bit, then words, continuing while selected.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defs.svh"
module serial_eeprom_command_port
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `MS_CYCLES(`WRITE_MS),
  parameter int unsigned ERASE_ALL_CMD_CYCLES  = `MS_CYCLES(`ERASE_ALL_CMD_MS),
  parameter int unsigned WRITE_ALL_CMD_CYCLES  = `MS_CYCLES(`WRITE_ALL_CMD_MS)
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       chip_select,
  input  wire logic       serial_clock,
  input  wire logic       serial_data_in,
  input  wire logic       word_width_select,
  input  wire logic [1:0] density_sel,
  output logic            serial_data_out,
  output logic            serial_data_out_oe
);
  localparam logic [5:0] GAP = 6'(`GAP_CYCLES);

  logic [7:0]  mem [`MEM_BYTES];
  geom_s       geom;
  phase_e      phase;
  phase_e      next_phase;
  logic        sclk_q;
  logic        cs_q;
  logic [4:0]  cnt;
  logic [1:0]  opc;
  logic [8:0]  addr_sh;
  logic [15:0] data_sh;
  logic [8:0]  addr_next;
  logic [15:0] data_next;
  logic [8:0]  cmd_src;
  logic [1:0]  ext_cmd;
  logic        shift_edge;
  logic        cs_fall;
  logic        cs_rise;
  logic        start_det;
  logic        last_opc;
  logic        last_addr;
  logic        last_data;
  logic        is_ext;
  logic        needs_data;
  logic        rd_go;
  logic        prog_enable;
  logic        pend;
  job_s        job;
  job_s        new_job;
  logic        job_done;
  logic        prog_start;
  logic        busy;
  logic        walking;
  logic [8:0]  walk_ptr;
  logic [7:0]  walk_byte;
  logic [7:0]  hi_byte;
  logic [7:0]  lo_byte;
  logic [22:0] duration;
  logic [5:0]  gap_cnt;
  logic        gap_ok;
  logic        armed;
  logic        show;
  logic        pf_active;
  logic [8:0]  pf_addr;
  logic [15:0] pf_word;
  logic        pf_ready;
  logic        out_valid;
  logic        out_pop;
  logic [15:0] out_data;
  logic [15:0] aligned;
  logic [15:0] out_sh;
  logic [4:0]  out_left;
  logic        out_bit;
  logic [5:0]  bits_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Edge and phase decoding; the pins are synchronous to clk
  assign geom       = geometry(density_sel, word_width_select);
  assign shift_edge = chip_select & serial_clock & ~sclk_q;
  assign cs_fall    = cs_q & ~chip_select;
  assign cs_rise    = chip_select & ~cs_q;
  // Start bits are refused while busy or while a finished job waits for select low
  assign start_det  = shift_edge & (phase == ST_IDLE) & serial_data_in
                      & ~busy & ~pend;
  assign addr_next  = {addr_sh[7:0], serial_data_in};
  assign data_next  = {data_sh[14:0], serial_data_in};
  assign last_opc   = (phase == ST_OPC) & (cnt == 5'h01);
  assign last_addr  = (phase == ST_ADDR) & (cnt == {1'b0, geom.alen} - 5'h01);
  assign last_data  = (phase == ST_DATA) & (cnt == geom.dlen - 5'h01);
  // Data phase keeps shifting addr_next, so the address is taken from addr_sh there
  assign cmd_src    = (phase == ST_DATA) ? addr_sh : addr_next;
  assign ext_cmd    = cmd_src[geom.alen - 4'h2 +: 2];
  assign is_ext     = (opc == `OPC_EXT);
  assign needs_data = (opc == `OPC_WRITE) | (is_ext & (ext_cmd == `EXT_WRALL));
  assign rd_go      = shift_edge & last_addr & (opc == `OPC_READ);

  // Next phase of the instruction walk
  always_comb begin
    next_phase = phase;
    case (phase)
      ST_IDLE: if (start_det) next_phase = ST_OPC;
      ST_OPC:  if (last_opc) next_phase = ST_ADDR;
      ST_ADDR: begin
        if (last_addr) begin
          next_phase = (opc == `OPC_READ) ? ST_READ : needs_data ? ST_DATA : ST_IDLE;
        end
      end
      ST_DATA: if (last_data) next_phase = ST_IDLE;
      ST_READ: next_phase = ST_READ;
      default: next_phase = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction shifter; while selected, state only moves on a rising serial edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase   <= ST_IDLE;
      cnt     <= 5'h00;
      opc     <= 2'h0;
      addr_sh <= 9'h000;
      data_sh <= 16'h0000;
    end else if (!chip_select) begin
      phase <= ST_IDLE;
      cnt   <= 5'h00;
    end else if (shift_edge) begin
      phase <= next_phase;
      cnt   <= (next_phase != phase) ? 5'h00 : cnt + 5'h01;
      if (phase == ST_OPC) opc <= {opc[0], serial_data_in};
      if (phase == ST_ADDR) addr_sh <= addr_next;
      if (phase == ST_DATA) data_sh <= data_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b0;
    end else begin
      sclk_q <= serial_clock;
      cs_q   <= chip_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completed instructions become a job that starts at the select falling edge
  assign new_job.addr = byte_addr(cmd_src, geom);
  assign new_job.data = data_next;
  assign new_job.kind = (!last_data && opc == `OPC_ERASE) ? JOB_ERASE :
                        (!last_data) ? JOB_ERASE_ALL_CMD :
                        (opc == `OPC_WRITE) ? JOB_WRITE : JOB_WRITE_ALL_CMD;
  assign job_done     = shift_edge & prog_enable &
                        ((last_addr & (opc == `OPC_ERASE)) |
                         (last_addr & is_ext & (ext_cmd == `EXT_ERALL)) |
                         (last_data & needs_data));
  assign prog_start   = cs_fall & pend;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_enable <= 1'b0;
      pend        <= 1'b0;
      job         <= '0;
    end else begin
      if (shift_edge && last_addr && is_ext && ext_cmd == `EXT_ENABLE) prog_enable <= 1'b1;
      if (shift_edge && last_addr && is_ext && ext_cmd == `EXT_DISABLE) prog_enable <= 1'b0;
      if (job_done) begin
        pend <= 1'b1;
        job  <= new_job;
      end else if (prog_start) begin
        pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming: single words at the start, whole-array jobs walk byte by byte
  assign duration  = (job.kind == JOB_ERASE_ALL_CMD) ? 23'(ERASE_ALL_CMD_CYCLES) :
                     (job.kind == JOB_WRITE_ALL_CMD) ? 23'(WRITE_ALL_CMD_CYCLES) : 23'(WRITE_CYCLES);
  assign hi_byte   = (job.kind == JOB_ERASE) ? 8'hFF :
                     geom.wide ? job.data[15:8] : job.data[7:0];
  assign lo_byte   = (job.kind == JOB_ERASE) ? 8'hFF : job.data[7:0];
  assign walk_byte = (job.kind == JOB_ERASE_ALL_CMD) ? 8'hFF :
                     (geom.wide && !walk_ptr[0]) ? job.data[15:8] : job.data[7:0];

  program_timer u_timer (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .load       (prog_start),
    .load_value (duration),
    .running    (busy)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      walking  <= 1'b0;
      walk_ptr <= 9'h000;
    end else if (prog_start) begin
      walking  <= (job.kind == JOB_ERASE_ALL_CMD) | (job.kind == JOB_WRITE_ALL_CMD);
      walk_ptr <= 9'h000;
    end else if (walking) begin
      walking  <= (walk_ptr != geom.mask);
      walk_ptr <= wrap_inc(walk_ptr, 2'h1, geom.mask);
    end
  end

  // Array has no reset; contents survive like a nonvolatile store
  always_ff @(posedge clk) begin
    if (prog_start && (job.kind == JOB_ERASE || job.kind == JOB_WRITE)) begin
      mem[job.addr] <= hi_byte;
      if (geom.wide) mem[wrap_inc(job.addr, 2'h1, geom.mask)] <= lo_byte;
    end else if (walking) begin
      mem[walk_ptr] <= walk_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status polling: needs a long enough low gap, then a rising select
  assign gap_ok = (gap_cnt == GAP);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt <= 6'h00;
      armed   <= 1'b0;
      show    <= 1'b0;
    end else begin
      if (chip_select) gap_cnt <= 6'h00;
      else if (!gap_ok) gap_cnt <= gap_cnt + 6'h01;
      if (prog_start) armed <= 1'b1;
      else if (start_det) armed <= 1'b0;
      if (!chip_select || start_det) show <= 1'b0;
      else if (cs_rise && gap_ok && armed) show <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read prefetch: fills the buffer ahead of the slow serial output
  assign pf_word = geom.wide ? {mem[pf_addr], mem[wrap_inc(pf_addr, 2'h1, geom.mask)]}
                             : {8'h00, mem[pf_addr]};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_active <= 1'b0;
      pf_addr   <= 9'h000;
    end else if (!chip_select) begin
      pf_active <= 1'b0;
    end else if (rd_go) begin
      pf_active <= 1'b1;
      pf_addr   <= byte_addr(addr_next, geom);
    end else if (pf_active && pf_ready) begin
      pf_addr   <= wrap_inc(pf_addr, geom.wide ? 2'h2 : 2'h1, geom.mask);
    end
  end

  word_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clear     (~chip_select),
    .in_valid  (pf_active),
    .in_ready  (pf_ready),
    .in_data   (pf_word),
    .out_valid (out_valid),
    .out_ready (out_pop),
    .out_data  (out_data)
  );

  // Output shifter; a starved buffer reads as all ones rather than stalling
  assign out_pop = shift_edge & (phase == ST_READ) & (out_left == 5'h00);
  assign aligned = !out_valid ? 16'hFFFF :
                   geom.wide ? out_data : {out_data[7:0], 8'h00};
  assign out_bit = (out_left == 5'h00) ? aligned[15] : out_sh[15];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_sh   <= 16'h0000;
      out_left <= 5'h00;
    end else if (rd_go) begin
      out_left <= 5'h00;
    end else if (shift_edge && phase == ST_READ) begin
      out_sh   <= (out_left == 5'h00) ? {aligned[14:0], 1'b0} : {out_sh[14:0], 1'b0};
      out_left <= (out_left == 5'h00) ? geom.dlen - 5'h01 : out_left - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output pin: read data, status, or released
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else if (!chip_select) begin
      serial_data_out_oe <= 1'b0;
    end else if (rd_go) begin
      serial_data_out_oe <= 1'b1;
      serial_data_out    <= 1'b0;
    end else if (phase == ST_READ) begin
      if (shift_edge) serial_data_out <= out_bit;
    end else begin
      serial_data_out_oe <= show;
      serial_data_out    <= ~busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks; bits_seen counts every clocked bit of the current instruction
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) bits_seen <= 6'h00;
    else if (start_det) bits_seen <= 6'h01;
    else if (shift_edge && phase != ST_IDLE) bits_seen <= bits_seen + 6'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence read_addr_done;
    rd_go;
  endsequence
  sequence dummy_zero;
    serial_data_out_oe && !serial_data_out;
  endsequence

  deselect_reset_a: assert property (!chip_select |=> phase == ST_IDLE)
    else $error("command logic not reset while deselected");
  deselect_hiz_a: assert property (!chip_select |=> !serial_data_out_oe)
    else $error("output driven while deselected");
  clock_pause_a: assert property ((chip_select && !shift_edge) |=>
    $stable(phase) && $stable(cnt))
    else $error("state moved without a rising serial edge");
  idle_wait_a: assert property ((phase == ST_IDLE && !start_det) |=> phase == ST_IDLE)
    else $error("left idle without a start bit");
  short_count_a: assert property ((shift_edge && last_addr && !needs_data &&
    opc != `OPC_READ) |-> bits_seen + 6'h01 == 6'h03 + {2'h0, geom.alen})
    else $error("short instruction clock count wrong");
  data_count_a: assert property ((shift_edge && last_data) |->
    bits_seen + 6'h01 == 6'h03 + {2'h0, geom.alen} + {1'b0, geom.dlen})
    else $error("data instruction clock count wrong");
  dummy_bit_a: assert property (read_addr_done |=> dummy_zero)
    else $error("read did not open with a zero bit");
  status_gap_a: assert property ($rose(show) |-> $past(gap_ok) && $past(armed))
    else $error("status shown without a full deselect gap");
  status_level_a: assert property ((show && chip_select && phase == ST_IDLE) |=>
    serial_data_out_oe && serial_data_out == !$past(busy))
    else $error("status level does not follow busy");
  enable_gate_a: assert property ((shift_edge && phase != ST_IDLE && !prog_enable) |=>
    !pend)
    else $error("programming accepted while disabled");
  prog_hold_a: assert property (prog_start |=> busy [*3])
    else $error("programming cycle cut short");
endmodule
`default_nettype wire

// [inc/eeprom_defs.svh]
// Constants for the serial memory command port: timing, encodings, geometry.
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

`define CLK_MHZ        200
`define GAP_NS         250
`define GAP_CYCLES     ((`GAP_NS * `CLK_MHZ + 999) / 1000)
`define WRITE_MS       10
`define ERASE_ALL_CMD_MS        15
`define WRITE_ALL_CMD_MS        30
`define MS_CYCLES(ms)  ((ms) * 1000 * `CLK_MHZ)

`define OPC_EXT        2'h0
`define OPC_WRITE      2'h1
`define OPC_READ       2'h2
`define OPC_ERASE      2'h3
`define EXT_DISABLE    2'h0
`define EXT_WRALL      2'h1
`define EXT_ERALL      2'h2
`define EXT_ENABLE     2'h3

`define DATA_W         16
`define FIFO_DEPTH     16
`define MEM_BYTES      512
`define ALEN_1K_8      4'h7
`define ALEN_1K_16     4'h6
`define ALEN_2K_8      4'h9
`define ALEN_2K_16     4'h8
`define ALEN_4K_8      4'h9
`define DLEN_8         5'h08
`define DLEN_16        5'h10
`define MASK_1K        9'h07F
`define MASK_2K        9'h0FF
`define MASK_4K        9'h1FF

`endif

// [inc/eeprom_pkg.sv]
// Types and shared helpers for the serial memory command port.
`include "eeprom_defs.svh"
package eeprom_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_OPC = 3'h1, ST_ADDR = 3'h3, ST_DATA = 3'h2, ST_READ = 3'h6
  } phase_e;
  typedef enum logic [1:0] {JOB_ERASE, JOB_WRITE, JOB_ERASE_ALL_CMD, JOB_WRITE_ALL_CMD} job_e;
  typedef struct packed {
    job_e        kind;
    logic [8:0]  addr;
    logic [15:0] data;
  } job_s;
  typedef struct packed {
    logic [3:0] alen;
    logic [4:0] dlen;
    logic [8:0] mask;
    logic       wide;
  } geom_s;

  // Density 0 = 1K, 1 = 2K, 2/3 = 4K; the 4K part has no 16-bit mode
  function automatic geom_s geometry(input logic [1:0] dens, input logic wide_pin);
    geom_s g;
    g.wide = wide_pin & ~dens[1];
    g.dlen = g.wide ? `DLEN_16 : `DLEN_8;
    case (dens)
      2'h0: begin
        g.alen = g.wide ? `ALEN_1K_16 : `ALEN_1K_8;
        g.mask = `MASK_1K;
      end
      2'h1: begin
        g.alen = g.wide ? `ALEN_2K_16 : `ALEN_2K_8;
        g.mask = `MASK_2K;
      end
      default: begin
        g.alen = `ALEN_4K_8;
        g.mask = `MASK_4K;
      end
    endcase
    return g;
  endfunction

  // Byte location of a word address; unused leading address bits fall away
  function automatic logic [8:0] byte_addr(input logic [8:0] a, input geom_s g);
    logic [9:0] t;
    t = g.wide ? {a, 1'b0} : {1'b0, a};
    return t[8:0] & g.mask;
  endfunction

  // Step a byte pointer, wrapping inside the array
  function automatic logic [8:0] wrap_inc(input logic [8:0] a, input logic [1:0] n,
                                          input logic [8:0] mask);
    return (a + {7'h00, n}) & mask;
  endfunction
endpackage

// [design/program_timer.sv]
// Self-timed programming interval counter.
`timescale 1ns/1ps
`default_nettype none
module program_timer
  import eeprom_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        load,
  input  wire logic [22:0] load_value,
  output logic             running
);
  logic [22:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // Runs on the system clock only, so no serial clock is needed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 23'h000000;
    end else if (load) begin
      count <= load_value;
    end else if (count != 23'h000000) begin
      count <= count - 23'h000001;
    end
  end

  assign running = (count != 23'h000000);

  ////////////////////////////////////////////////////////////////////////////
  timer_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    load |=> count == $past(load_value))
    else $error("timer did not take its load value");
  timer_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (running && !load) |=> count == $past(count) - 23'h000001)
    else $error("timer stalled while programming");
endmodule
`default_nettype wire

// [design/word_fifo.sv]
// Parameterised first-in first-out buffer with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = ~((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = store[rd_ptr[AW-1:0]];
  assign push      = in_valid & in_ready & ~clear;
  assign pop       = out_valid & out_ready & ~clear;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  fifo_no_overrun_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!in_ready && !clear && !pop) |=> $stable(wr_ptr))
    else $error("fifo accepted a word while full");
endmodule
`default_nettype wire

// [tb/serial_master.sv]
// Host-side serial master model: select, serial clock and serial input.
`timescale 1ns/1ps
`default_nettype none
module serial_master (
  input  wire logic clk,
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One bit; levels held 4 clk so the device sees each edge cleanly
  task automatic put(input logic b, output logic q);
    serial_data_in = b;
    repeat (4) @(negedge clk);
    serial_clock = 1'b1;
    repeat (2) @(negedge clk);
    q = serial_data_out;
    repeat (2) @(negedge clk);
    serial_clock = 1'b0;
  endtask
  // Selects, then shifts a field MSB first; r gathers output bits
  task automatic send(input logic [26:0] v, input int n, output logic [15:0] r);
    logic q;
    chip_select = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      put(v[i], q);
      r = {r[14:0], q};
    end
  endtask
  // Deselect gap; input flipped so a stale level is never trusted
  task automatic gap(input int n);
    chip_select = 1'b0;
    serial_data_in = ~serial_data_in;
    repeat (n) @(negedge clk);
  endtask
  // Reselect without clocking, to poll status
  task automatic sel();
    chip_select = 1'b1;
    repeat (3) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// [tb/serial_eeprom_command_port_tb.sv]
// Self-checking bench for the serial memory command port, several geometries.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_port_tb;
  import eeprom_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        chip_select;
  logic        serial_clock;
  logic        serial_data_in;
  logic        serial_data_out;
  logic        serial_data_out_oe;
  logic        pin;
  logic        wide = 1'b0;
  logic [1:0]  dens = 2'h0;
  logic [15:0] r;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #2.5 clk = ~clk;
  // Pull-up on the output line: a released pin reads high
  assign pin = serial_data_out_oe ? serial_data_out : 1'b1;
  // Short programming times keep the run small; must exceed 512
  serial_eeprom_command_port #(.WRITE_CYCLES(600), .ERASE_ALL_CMD_CYCLES(600),
    .WRITE_ALL_CMD_CYCLES(600)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .chip_select(chip_select), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .word_width_select(wide),
    .density_sel(dens), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe));
  serial_master m_u (.clk(clk), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .serial_data_out(pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard: whole run needs about 8700 clk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Selected, clocked with input low: no start, pin stays released
  task automatic t_idle();
    m_u.send(27'h0, 6, r);
    check("idle_oe", {15'h0, serial_data_out_oe}, 16'h0);
    m_u.gap(60);
  endtask
  // Extended group: v holds start, opcode 00, command bits and filler
  task automatic t_ext(input logic [26:0] v, input int n);
    m_u.send(v, n, r);
    check("ext_oe", {15'h0, serial_data_out_oe}, 16'h0);
    m_u.gap(60);
  endtask
  // Erase or write; status polled after the gap, shown only when enabled
  task automatic t_prog(input logic [26:0] v, input int n, input logic en);
    m_u.send(v, n, r);
    m_u.gap(60);
    m_u.sel();
    check("busy", {14'h0, serial_data_out_oe, pin}, en ? 16'h2 : 16'h1);
    repeat (700) @(negedge clk);
    if (en) check("ready", {15'h0, serial_data_out}, 16'h1);
    m_u.gap(60);
  endtask
  // Read: dummy zero, then the word MSB first, then release
  task automatic t_read(input logic [26:0] v, input int n, input int dw, input logic [15:0] d);
    m_u.send(v, n, r);
    check("dummy", {15'h0, r[0]}, 16'h0);
    m_u.send(27'h0, dw, r);
    check("rdata", (dw == 8) ? {8'h0, r[7:0]} : r, d);
    m_u.gap(3);
    check("rel_oe", {15'h0, serial_data_out_oe}, 16'h0);
    m_u.gap(60);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_idle();
    t_prog({9'h0, 3'b101, 7'h05, 8'hA5}, 18, 1'b0);
    t_ext(27'h260, 10);
    t_prog({9'h0, 3'b101, 7'h05, 8'hA5}, 18, 1'b1);
    m_u.send(27'h18, 5, r); // Partial read dropped by select low
    m_u.gap(60);
    t_read({17'h0, 3'b110, 7'h05}, 10, 8, 16'h00A5);
    t_prog({17'h0, 3'b111, 7'h06}, 10, 1'b1);
    t_read({17'h0, 3'b110, 7'h06}, 10, 8, 16'h00FF);
    t_ext(27'h200, 10);
    t_prog({9'h0, 3'b101, 7'h05, 8'h3C}, 18, 1'b0);
    t_read({17'h0, 3'b110, 7'h05}, 10, 8, 16'h00A5);
    // 1K in word width
    wide = 1'b1;
    t_ext(27'h130, 9);
    t_prog({2'h0, 3'b101, 6'h03, 16'h5AC3}, 25, 1'b1);
    t_read({18'h0, 3'b110, 6'h03}, 9, 16, 16'h5AC3);
    // 2K in byte width: erase all, then write all; leading address bit ignored
    wide = 1'b0;
    dens = 2'h1;
    t_prog(27'h900, 12, 1'b1);
    t_read({15'h0, 3'b110, 9'h105}, 12, 8, 16'h00FF);
    t_prog({7'h0, 3'b100, 2'b01, 7'h00, 8'h3C}, 20, 1'b1);
    t_read({15'h0, 3'b110, 9'h010}, 12, 8, 16'h003C);
    report_and_stop();
  end
endmodule
`default_nettype wire
